// ---- src/tmd_axis.sv ----
// Purpose: One axis of transient detection with its debounce counter.
// Assumes: step is a one-cycle pulse from the step prescaler.
// Notes: hit and polarity change only on a step or when disabled.
`timescale 1ns/1ps
`default_nettype none
module tmd_axis (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic step,
    input wire logic enable,
    input wire logic [7:0] sample,
    input wire logic [6:0] thr,
    input wire logic clear_mode,
    input wire logic [7:0] count,
    output logic hit_r,
    output logic pol_r
);
    import tmd_pkg::*;

    logic [7:0] cnt_r, cnt_nxt;
    logic hit_nxt, pol_nxt;
    logic [7:0] mag;
    logic cond;

    // Unsigned magnitude against the threshold
    assign mag = sample[7] ? 8'(~sample + 8'h01) : sample;
    assign cond = enable && (mag > {1'b0, thr});

    always_comb begin
        cnt_nxt = cnt_r;
        hit_nxt = hit_r;
        pol_nxt = pol_r;
        if (!enable) begin
            cnt_nxt = 8'h00;
            hit_nxt = 1'b0;
        end else if (step) begin
            if (cond) begin
                cnt_nxt = (cnt_r < count)
                    ? 8'(cnt_r + 8'h01) : count;
                hit_nxt = (cnt_nxt == count);
                pol_nxt = sample[7];
            end else begin
                if (clear_mode) cnt_nxt = 8'h00;
                else if (cnt_r != 8'h00) cnt_nxt = 8'(cnt_r - 8'h01);
                hit_nxt = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= 8'h00;
            hit_r <= 1'b0;
            pol_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            hit_r <= hit_nxt;
            pol_r <= pol_nxt;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_cnt_cap;
        step && cond |=> cnt_r <= $past(count);
    endproperty
    a_cnt_cap: assert property (p_cnt_cap)
        else $error("debounce counter passed the count");

    property p_hit_reach;
        step && cond && (({1'b0, cnt_r} + 9'h001) >= {1'b0, count}) |=> hit_r;
    endproperty
    a_hit_reach: assert property (p_hit_reach)
        else $error("hit missing when count reached");

    property p_clear;
        step && enable && !cond && clear_mode |=> cnt_r == 8'h00 && !hit_r;
    endproperty
    a_clear: assert property (p_clear)
        else $error("counter not cleared in clear mode");

    property p_dec;
        step && enable && !cond && !clear_mode && cnt_r != 8'h00
            |=> cnt_r == 8'($past(cnt_r) - 8'h01);
    endproperty
    a_dec: assert property (p_dec)
        else $error("counter not decremented by one");

    property p_disabled;
        !enable |=> !hit_r && cnt_r == 8'h00;
    endproperty
    a_disabled: assert property (p_disabled)
        else $error("disabled axis still active");

endmodule : tmd_axis
`default_nettype wire

// ---- src/tmd_pkg.sv ----
// Purpose: Constants, types and tables for the transient motion detector.
// Assumes: 200 MHz clock; samples are signed 8-bit at 0.0625 g per count.
// Notes: Register byte address is four times the register index.
//
// How it works
// - Event-active bit is high exactly while any axis event flag is high.
// - Z event bit sets above threshold; Z polarity one means negative.
// - Y event bit sets above threshold; Y polarity one means negative.
// - X event bit sets above threshold; X polarity one means negative.
// - Latching on, event-active set freezes the other status bits.
// - Reading the source register clears it and releases the interrupt.
// - Filtered data is compared; interrupt only when interrupt is enabled.
// - Threshold is seven unsigned bits, 0.063 g per count, reset zero.
// - Threshold spans 8 g whatever the full-scale range.
// - Low-noise bit caps the reachable threshold at 4 g.
// - Threshold bit seven picks decrement (0) or clear (1) debounce.
// - Count register holds the debounce steps needed before flagging.
// - Debounce counter steps at a rate set by sample rate and mode.
// - Step is 1.25 ms at 800 Hz up to 160 ms in low-power mode.
// - Per-axis enable bits gate detection; zero disables that axis.
// - Bypass bit feeds unfiltered data to the comparator when one.
// - Latch enable holds event flags until the source register is read.
// - Clear mode zeroes the counter; decrement mode drops one a step.
package tmd_pkg;

    localparam int CLK_PERIOD_NS = 5;
    localparam int STEP_BASE_NS = 1250000;
    localparam int STEP_BASE_CYC = STEP_BASE_NS / CLK_PERIOD_NS;
    localparam int BASE_W = 18;

    localparam logic [5:0] IDX_CFG = 6'h1D;
    localparam logic [5:0] IDX_SRC = 6'h1E;
    localparam logic [5:0] IDX_THR = 6'h1F;
    localparam logic [5:0] IDX_CNT = 6'h20;
    localparam logic [5:0] IDX_CTRL = 6'h2A;
    localparam logic [5:0] IDX_MODE = 6'h2B;

    localparam int THR_MODE_POS = 7;
    localparam int CTRL_LN_POS = 0;
    localparam int CTRL_RATE_POS = 3;
    localparam int MODE_OSM_POS = 0;
    localparam int MODE_IRQ_POS = 2;
    localparam logic [7:0] CTRL_MASK = 8'h39;
    localparam logic [7:0] MODE_MASK = 8'h07;

    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [6:0] LN_THR_MAX = 7'h40;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        OSM_NORMAL, OSM_LOWNOISE, OSM_HIRES, OSM_LOWPWR
    } tmd_osm_t;

    typedef struct packed {
        logic [7:0] z;
        logic [7:0] y;
        logic [7:0] x;
    } tmd_axes_t;

    typedef struct packed {
        logic latch;
        logic zen;
        logic yen;
        logic xen;
        logic byp;
    } tmd_cfg_t;

    localparam tmd_cfg_t CFG_RST = 5'h00;

    // Debounce step in units of 1.25 ms, per rate code 0 (800 Hz) to 7
    function automatic logic [7:0] step_units(input logic [2:0] rate,
                                              input logic [1:0] osm);
        logic [7:0] u;
        u = 8'h01;
        case (rate)
            3'h0: u = 8'h01;
            3'h1: u = 8'h02;
            3'h2: u = 8'h04;
            3'h3: u = 8'h08;
            3'h4: u = 8'h10;
            3'h5: u = (osm == OSM_NORMAL) ? 8'h10 : 8'h40;
            default: begin
                if (osm == OSM_NORMAL) u = 8'h10;
                else if (osm == OSM_LOWPWR) u = 8'h80;
                else u = 8'h40;
            end
        endcase
        if (osm == OSM_HIRES && rate != 3'h0) u = 8'h02;
        return u;
    endfunction : step_units

endpackage : tmd_pkg

// ---- src/tmd_transient.sv ----
// Purpose: Transient detector with AXI4-Lite register access.
// Assumes: Sample inputs are synchronous levels, 0.0625 g per count.
// Notes: Source register clears on a successful read of it unless an update in that cycle flags an axis.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module tmd_transient #(
    parameter int STEP_BASE_CYCLES = tmd_pkg::STEP_BASE_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire tmd_pkg::tmd_axes_t hpf_sample,
    input wire tmd_pkg::tmd_axes_t raw_sample,
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    output logic transient_irq
);
    import tmd_pkg::*;

    // Bus and register state
    logic aw_full_r, aw_full_nxt;
    logic [5:0] aw_idx_r, aw_idx_nxt;
    logic aw_ok_r, aw_ok_nxt;
    logic w_full_r, w_full_nxt;
    logic [7:0] wdata_r, wdata_nxt;
    logic wen_r, wen_nxt;
    logic bvalid_r, bvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic [1:0] rresp_r, rresp_nxt;
    tmd_cfg_t cfg_r, cfg_nxt;
    logic [7:0] thr_r, thr_nxt;
    logic [7:0] count_r, count_nxt;
    logic [7:0] ctrl_r, ctrl_nxt;
    logic [7:0] mode_r, mode_nxt;

    // Step prescaler state
    logic [BASE_W-1:0] base_r, base_nxt;
    logic [7:0] unit_r, unit_nxt;
    logic upd_r, upd_nxt;
    logic step;
    logic [7:0] units;

    // Source register state
    logic [2:0] ev_r, ev_nxt;
    logic [2:0] pol_r, pol_nxt;
    logic act_r, act_nxt;

    logic do_write;
    logic ar_hs;
    logic [5:0] rd_idx;
    logic rd_ok;
    logic rd_clr;
    logic frozen;
    logic [7:0] src_byte;
    logic [6:0] thr_eff;
    logic [2:0][7:0] samp;
    logic [2:0] axis_en;
    logic [2:0] hits;
    logic [2:0] pols;

    function automatic logic is_mapped(input logic [5:0] idx);
        return idx == IDX_CFG || idx == IDX_SRC || idx == IDX_THR ||
               idx == IDX_CNT || idx == IDX_CTRL || idx == IDX_MODE;
    endfunction : is_mapped

    assign s_awready = !aw_full_r;
    assign s_wready = !w_full_r;
    assign s_bvalid = bvalid_r;
    assign s_bresp = bresp_r;
    assign s_arready = !rvalid_r;
    assign s_rvalid = rvalid_r;
    assign s_rdata = {24'h000000, rdata_r};
    assign s_rresp = rresp_r;

    assign do_write = aw_full_r && w_full_r && !bvalid_r;
    assign ar_hs = s_arvalid && !rvalid_r;
    assign rd_idx = s_araddr[7:2];
    assign rd_ok = (s_araddr[1:0] == 2'h0) && is_mapped(rd_idx);
    assign rd_clr = ar_hs && rd_ok && (rd_idx == IDX_SRC);

    assign src_byte = {1'b0, act_r, ev_r[2], pol_r[2], ev_r[1], pol_r[1],
                       ev_r[0], pol_r[0]};

    always_comb begin
        aw_full_nxt = aw_full_r;
        aw_idx_nxt = aw_idx_r;
        aw_ok_nxt = aw_ok_r;
        w_full_nxt = w_full_r;
        wdata_nxt = wdata_r;
        wen_nxt = wen_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        cfg_nxt = cfg_r;
        thr_nxt = thr_r;
        count_nxt = count_r;
        ctrl_nxt = ctrl_r;
        mode_nxt = mode_r;
        if (s_awvalid && !aw_full_r) begin
            aw_full_nxt = 1'b1;
            aw_idx_nxt = s_awaddr[7:2];
            aw_ok_nxt = (s_awaddr[1:0] == 2'h0);
        end
        if (s_wvalid && !w_full_r) begin
            w_full_nxt = 1'b1;
            wdata_nxt = s_wdata[7:0];
            wen_nxt = s_wstrb[0];
        end
        if (bvalid_r && s_bready) bvalid_nxt = 1'b0;
        if (do_write) begin
            aw_full_nxt = 1'b0;
            w_full_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = (aw_ok_r && is_mapped(aw_idx_r)) ? RESP_OKAY
                                                          : RESP_SLVERR;
            if (aw_ok_r && wen_r) begin
                case (aw_idx_r)
                    IDX_CFG: cfg_nxt = tmd_cfg_t'(wdata_r[4:0]);
                    IDX_THR: thr_nxt = wdata_r;
                    IDX_CNT: count_nxt = wdata_r;
                    IDX_CTRL: ctrl_nxt = wdata_r & CTRL_MASK;
                    IDX_MODE: mode_nxt = wdata_r & MODE_MASK;
                    default: ;
                endcase
            end
        end
        if (rvalid_r && s_rready) rvalid_nxt = 1'b0;
        if (ar_hs) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = rd_ok ? RESP_OKAY : RESP_SLVERR;
            rdata_nxt = 8'h00;
            if (rd_ok) begin
                case (rd_idx)
                    IDX_CFG: rdata_nxt = {3'h0, cfg_r};
                    IDX_SRC: rdata_nxt = src_byte;
                    IDX_THR: rdata_nxt = thr_r;
                    IDX_CNT: rdata_nxt = count_r;
                    IDX_CTRL: rdata_nxt = ctrl_r;
                    IDX_MODE: rdata_nxt = mode_r;
                    default: rdata_nxt = 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            aw_full_r <= 1'b0;
            aw_idx_r <= 6'h00;
            aw_ok_r <= 1'b0;
            w_full_r <= 1'b0;
            wdata_r <= 8'h00;
            wen_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            rvalid_r <= 1'b0;
            rdata_r <= 8'h00;
            rresp_r <= RESP_OKAY;
            cfg_r <= CFG_RST;
            thr_r <= REG_RST;
            count_r <= REG_RST;
            ctrl_r <= REG_RST;
            mode_r <= REG_RST;
        end else begin
            aw_full_r <= aw_full_nxt;
            aw_idx_r <= aw_idx_nxt;
            aw_ok_r <= aw_ok_nxt;
            w_full_r <= w_full_nxt;
            wdata_r <= wdata_nxt;
            wen_r <= wen_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
            cfg_r <= cfg_nxt;
            thr_r <= thr_nxt;
            count_r <= count_nxt;
            ctrl_r <= ctrl_nxt;
            mode_r <= mode_nxt;
        end
    end

    // Debounce step: base tick of 1.25 ms times a rate and mode multiple
    assign units = step_units(ctrl_r[CTRL_RATE_POS +: 3],
                              mode_r[MODE_OSM_POS +: 2]);

    always_comb begin
        base_nxt = BASE_W'(base_r + 1'b1);
        unit_nxt = unit_r;
        step = 1'b0;
        if (base_r >= BASE_W'(STEP_BASE_CYCLES - 1)) begin
            base_nxt = '0;
            if (unit_r >= 8'(units - 8'h01)) begin
                unit_nxt = 8'h00;
                step = 1'b1;
            end else begin
                unit_nxt = 8'(unit_r + 8'h01);
            end
        end
        upd_nxt = step;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            base_r <= '0;
            unit_r <= 8'h00;
            upd_r <= 1'b0;
        end else begin
            base_r <= base_nxt;
            unit_r <= unit_nxt;
            upd_r <= upd_nxt;
        end
    end

    // Fixed 8 g scale whatever the range; low-noise caps at 4 g
    assign thr_eff = (ctrl_r[CTRL_LN_POS] && thr_r[6:0] > LN_THR_MAX)
                     ? LN_THR_MAX : thr_r[6:0];
    assign samp = cfg_r.byp
        ? {raw_sample.z, raw_sample.y, raw_sample.x}
        : {hpf_sample.z, hpf_sample.y, hpf_sample.x};
    assign axis_en = {cfg_r.zen, cfg_r.yen, cfg_r.xen};

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_axis
            tmd_axis u_axis (
                .clk(clk),
                .rst_b(rst_b),
                .step(step),
                .enable(axis_en[g]),
                .sample(samp[g]),
                .thr(thr_eff),
                .clear_mode(thr_r[THR_MODE_POS]),
                .count(count_r),
                .hit_r(hits[g]),
                .pol_r(pols[g])
            );
        end
    endgenerate

    // Source register; an update in the read cycle wins over the clear
    assign frozen = cfg_r.latch && act_r && !rd_clr;

    always_comb begin
        ev_nxt = ev_r;
        pol_nxt = pol_r;
        if (rd_clr) begin
            ev_nxt = 3'h0;
            pol_nxt = 3'h0;
        end
        if (upd_r) begin
            if (!cfg_r.latch) begin
                ev_nxt = hits;
                pol_nxt = pols & hits;
            end else if (!frozen) begin
                ev_nxt = ev_nxt | hits;
                pol_nxt = (pol_nxt & ~hits) | (pols & hits);
            end
        end
        act_nxt = |ev_nxt;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ev_r <= 3'h0;
            pol_r <= 3'h0;
            act_r <= 1'b0;
        end else begin
            ev_r <= ev_nxt;
            pol_r <= pol_nxt;
            act_r <= act_nxt;
        end
    end

    assign transient_irq = act_r && mode_r[MODE_IRQ_POS];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_ea;
        act_r == (|ev_r);
    endproperty
    a_ea: assert property (p_ea)
        else $error("event-active bit disagrees with axis flags");

    sequence s_frozen;
        cfg_r.latch && act_r && !rd_clr;
    endsequence
    property p_freeze;
        s_frozen |=> $stable(ev_r) && $stable(pol_r);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("status bits changed while frozen");

    sequence s_src_read;
        rd_clr && !upd_r;
    endsequence
    property p_read_clear;
        s_src_read |=> src_byte == 8'h00 && !transient_irq;
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("source read did not clear");

    property p_irq_gate;
        !mode_r[MODE_IRQ_POS] |-> !transient_irq;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("interrupt raised while disabled");

    property p_low_noise;
        ctrl_r[CTRL_LN_POS] |-> thr_eff <= LN_THR_MAX;
    endproperty
    a_low_noise: assert property (p_low_noise)
        else $error("threshold above 4 g in low-noise mode");

    property p_follow;
        upd_r && !cfg_r.latch |=> ev_r == $past(hits);
    endproperty
    a_follow: assert property (p_follow)
        else $error("flags do not follow detection");

    property p_latch;
        upd_r && cfg_r.latch && !frozen && hits[0] |=> ev_r[0] && act_r;
    endproperty
    a_latch: assert property (p_latch)
        else $error("x event not latched");

endmodule : tmd_transient
`default_nettype wire

// ---- tb/tb.sv ----
// Purpose: Self-checking bench for the transient detector.
// Assumes: Step base shortened to 4 clocks; one register per bus word.
// Notes: Waits after sample changes cover several debounce steps.
`timescale 1ns/1ps
`default_nettype none
module tb;
    import tmd_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    tmd_axes_t hs = '0;
    tmd_axes_t rs = '0;
    tmd_axes_t hpf;
    tmd_axes_t raw;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic transient_irq;
    logic [1:0] s_bresp, s_rresp;
    logic [31:0] s_rdata;
    int errors = 0;
    int tests_run = 0;

    always #2.5 clk = ~clk;

    tmd_sample_src src (.clk(clk), .rst_b(rst_b), .hpf_set(hs),
        .raw_set(rs), .hpf_sample(hpf), .raw_sample(raw));

    tmd_transient #(.STEP_BASE_CYCLES(4)) dut (.clk(clk), .rst_b(rst_b),
        .hpf_sample(hpf), .raw_sample(raw), .s_awaddr(awaddr),
        .s_awvalid(awvalid), .s_awready(s_awready), .s_wdata(wdata),
        .s_wstrb(4'hF), .s_wvalid(wvalid), .s_wready(s_wready),
        .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(1'b1),
        .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(s_arready),
        .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
        .s_rready(1'b1), .transient_irq(transient_irq));

    task automatic print_verdict();
        if (errors == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : print_verdict

    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time,
                     seen, exp);
        end
    endtask : check

    task automatic wr(input logic [5:0] idx, input logic [7:0] d,
                      input logic [1:0] er);
        int n;
        logic a;
        logic w;
        awaddr <= {idx, 2'b00};
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            #1;
            a = awvalid && s_awready;
            w = wvalid && s_wready;
            if (s_bvalid === 1'b1) break;
            @(posedge clk);
            if (a) awvalid <= 1'b0;
            if (w) wvalid <= 1'b0;
        end
        if (n == 50) begin
            errors++;
            print_verdict();
        end
        check(40'({s_awready, s_wready, s_bresp}), 40'({2'h3, er}));
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [5:0] idx, input logic [7:0] e,
                      input logic [1:0] er);
        int n;
        logic a;
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            #1;
            a = arvalid && s_arready;
            if (s_rvalid === 1'b1) break;
            @(posedge clk);
            if (a) arvalid <= 1'b0;
        end
        if (n == 50) begin
            errors++;
            print_verdict();
        end
        check({5'h00, s_arready, s_rresp, s_rdata},
              {5'h00, 1'h0, er, 24'h000000, e});
        @(posedge clk);
    endtask : rd

    task automatic set_s(input logic [23:0] h, input logic [23:0] r);
        hs <= h;
        rs <= r;
    endtask : set_s

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_cyc

    task automatic t_reset();
        check(40'({s_awready, s_wready, s_arready}), 40'h7);
        check(40'(transient_irq), 40'h0);
        rd(IDX_CFG, 8'h00, RESP_OKAY);
        rd(IDX_SRC, 8'h00, RESP_OKAY);
        rd(IDX_THR, 8'h00, RESP_OKAY);
        rd(IDX_CNT, 8'h00, RESP_OKAY);
        rd(6'h21, 8'h00, RESP_SLVERR);
        wr(6'h3F, 8'h55, RESP_SLVERR);
    endtask : t_reset

    task automatic t_rw();
        wr(IDX_THR, 8'hAB, RESP_OKAY);
        rd(IDX_THR, 8'hAB, RESP_OKAY);
        wr(IDX_CNT, 8'h5A, RESP_OKAY);
        rd(IDX_CNT, 8'h5A, RESP_OKAY);
        wr(IDX_CFG, 8'hFF, RESP_OKAY);
        rd(IDX_CFG, 8'h1F, RESP_OKAY);
    endtask : t_rw

    // Latch off: X disabled, Z positive, Y negative
    task automatic t_follow();
        wr(IDX_CFG, 8'h0C, RESP_OKAY);
        wr(IDX_THR, 8'h90, RESP_OKAY);
        wr(IDX_CNT, 8'h02, RESP_OKAY);
        set_s(24'h30E020, 24'h000000);
        wait_cyc(30);
        check(40'(transient_irq), 40'h0);
        rd(IDX_SRC, 8'h6C, RESP_OKAY);
        set_s(24'h000000, 24'h000000);
        wait_cyc(30);
        rd(IDX_SRC, 8'h00, RESP_OKAY);
    endtask : t_follow

    // Latch on: Z event freezes, later X event and Z drop are ignored
    task automatic t_latch();
        wr(IDX_MODE, 8'h04, RESP_OKAY);
        wr(IDX_CFG, 8'h1E, RESP_OKAY);
        set_s(24'hE00000, 24'h000000);
        wait_cyc(30);
        check(40'(transient_irq), 40'h1);
        set_s(24'h000020, 24'h000000);
        wait_cyc(30);
        set_s(24'h000000, 24'h000000);
        wait_cyc(30);
        rd(IDX_SRC, 8'h70, RESP_OKAY);
        rd(IDX_SRC, 8'h00, RESP_OKAY);
        check(40'(transient_irq), 40'h0);
    endtask : t_latch

    task automatic t_bypass();
        wr(IDX_CFG, 8'h03, RESP_OKAY);
        set_s(24'h000000, 24'h0000D0);
        wait_cyc(30);
        rd(IDX_SRC, 8'h43, RESP_OKAY);
        wr(IDX_CFG, 8'h02, RESP_OKAY);
        set_s(24'h0000D0, 24'h000000);
        wait_cyc(30);
        rd(IDX_SRC, 8'h43, RESP_OKAY);
        set_s(24'h000000, 24'h000000);
        wait_cyc(30);
    endtask : t_bypass

    // Full threshold misses 0x50; low-noise cap brings it to 0x40
    task automatic t_noise();
        wr(IDX_THR, 8'hFF, RESP_OKAY);
        set_s(24'h000050, 24'h000000);
        wait_cyc(30);
        rd(IDX_SRC, 8'h00, RESP_OKAY);
        wr(IDX_CTRL, 8'h01, RESP_OKAY);
        wait_cyc(30);
        rd(IDX_SRC, 8'h42, RESP_OKAY);
        set_s(24'h000000, 24'h000000);
        wait_cyc(30);
    endtask : t_noise

    // High-res at the slowest rate steps every 8 clocks; count 4 needs 4
    // Then decrement mode: two quiet steps cost two, clear mode would cost 4
    task automatic t_step();
        wr(IDX_CTRL, 8'h38, RESP_OKAY);
        wr(IDX_MODE, 8'h06, RESP_OKAY);
        wr(IDX_THR, 8'h90, RESP_OKAY);
        wr(IDX_CNT, 8'h04, RESP_OKAY);
        set_s(24'h000020, 24'h000000);
        wait_cyc(20);
        rd(IDX_SRC, 8'h00, RESP_OKAY);
        wait_cyc(40);
        rd(IDX_SRC, 8'h42, RESP_OKAY);
        wr(IDX_THR, 8'h10, RESP_OKAY);
        set_s(24'h000000, 24'h000000);
        wait_cyc(16);
        set_s(24'h000020, 24'h000000);
        wait_cyc(22);
        rd(IDX_SRC, 8'h42, RESP_OKAY);
    endtask : t_step

    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_reset();
        t_rw();
        t_follow();
        t_latch();
        t_bypass();
        t_noise();
        t_step();
        print_verdict();
    end

    initial begin
        repeat (90000) @(posedge clk);
        errors++;
        print_verdict();
    end
endmodule : tb
`default_nettype wire

// ---- tb/tmd_sample_src.sv ----
// Purpose: Sample path model feeding filtered and raw axis samples.
// Assumes: The bench sets the wanted samples; they land one clock later.
// Notes: Both paths read zero while reset is asserted.
`timescale 1ns/1ps
`default_nettype none
module tmd_sample_src (
    input wire logic clk,
    input wire logic rst_b,
    input wire tmd_pkg::tmd_axes_t hpf_set,
    input wire tmd_pkg::tmd_axes_t raw_set,
    output var tmd_pkg::tmd_axes_t hpf_sample,
    output var tmd_pkg::tmd_axes_t raw_sample
);
    import tmd_pkg::*;
    // Filtered and raw paths are kept apart so the bypass route shows
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hpf_sample <= '0;
            raw_sample <= '0;
        end else begin
            hpf_sample <= hpf_set;
            raw_sample <= raw_set;
        end
    end
endmodule : tmd_sample_src
`default_nettype wire
